// file: src/sdbc_bus_cycles.sv
// SRAM and DRAM external bus cycle generator with AXI4-Lite configuration
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdbc_bus_cycles #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [28:0] reqAddr,
  input wire logic [2:0] reqSize,
  input wire logic [7:0] reqBe,
  input wire logic [63:0] wrData,
  output logic wrTaken,
  output logic [63:0] rdData,
  output logic rdValid,
  output logic done,
  output logic busLock,
  output logic [25:0] addrOut,
  output logic [63:0] dataOut,
  output logic dataOe,
  input wire logic [63:0] dataIn,
  input wire logic waitReqN,
  output logic bus_start_pulseN,
  output logic [6:0] area_selectN,
  output logic readStrobeN,
  output logic [7:0] writeStrobeN,
  output logic rowStrobeN,
  output logic area2_row_strobeN,
  output logic [7:0] colStrobeN,
  output logic rdWr
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [4:0] waitCycles(input logic [2:0] f);
    waitCycles = {1'b0, sdbc_pkg::WAIT_TABLE[f*4 +: 4]};
  endfunction
  function automatic logic [25:0] rowAddr(input logic [28:0] a, input logic [2:0] sel);
    logic [4:0] sh;
    sh = sdbc_pkg::MUX_BASE + {2'h0, sel};
    rowAddr = a[25:0];
    for (int k = 1; k <= 17; k++) begin
      if (k + sh <= 25) begin
        rowAddr[k] = a[k + sh];
      end
    end
  endfunction

  // ----------------------------------------
  // Registers and AXI4-Lite slave
  // ----------------------------------------
  logic [31:0] bus_config_reg_one_q, wait_count_reg_q, memory_ctrl_reg_q, setup_hold_reg_q;
  logic awTaken_q, wTaken_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q, rdataReg_q, statusWord;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;
  sdbc_pkg::sdbc_state_t state_q;
  logic [5:0] beatsLeft_q;

  assign s_axi_awready = !awTaken_q && !bvalid_q;
  assign s_axi_wready = !wTaken_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdataReg_q;
  assign s_axi_rresp = rresp_q;
  assign statusWord = {22'h0, beatsLeft_q, state_q};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awTaken_q <= 1'b0;
      wTaken_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= sdbc_pkg::RESP_OKAY;
      awAddr_q <= '0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bus_config_reg_one_q <= sdbc_pkg::BUSCFG_RST;
      wait_count_reg_q <= sdbc_pkg::WAIT_RST;
      memory_ctrl_reg_q <= sdbc_pkg::MEMCTL_RST;
      setup_hold_reg_q <= sdbc_pkg::HOLD_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (awTaken_q && wTaken_q && !bvalid_q) begin
        awTaken_q <= 1'b0;
        wTaken_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= sdbc_pkg::RESP_OKAY;
        unique case (8'(awAddr_q))
          sdbc_pkg::OFS_BUSCFG: bus_config_reg_one_q <= merge(bus_config_reg_one_q, wData_q, wStrb_q);
          sdbc_pkg::OFS_WAIT: wait_count_reg_q <= merge(wait_count_reg_q, wData_q, wStrb_q);
          sdbc_pkg::OFS_MEMCTL: memory_ctrl_reg_q <= merge(memory_ctrl_reg_q, wData_q, wStrb_q);
          sdbc_pkg::OFS_HOLD: setup_hold_reg_q <= merge(setup_hold_reg_q, wData_q, wStrb_q);
          default: bresp_q <= sdbc_pkg::RESP_SLVERR;
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
      rdataReg_q <= 32'h0;
      rresp_q <= sdbc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= sdbc_pkg::RESP_OKAY;
      unique case (8'(s_axi_araddr))
        sdbc_pkg::OFS_BUSCFG: rdataReg_q <= bus_config_reg_one_q;
        sdbc_pkg::OFS_WAIT: rdataReg_q <= wait_count_reg_q;
        sdbc_pkg::OFS_MEMCTL: rdataReg_q <= memory_ctrl_reg_q;
        sdbc_pkg::OFS_HOLD: rdataReg_q <= setup_hold_reg_q;
        sdbc_pkg::OFS_STATUS: rdataReg_q <= statusWord;
        default: begin
          rdataReg_q <= 32'h0;
          rresp_q <= sdbc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  logic [2:0] memory_type_sel, mux_select, tpc, reqArea;
  logic [1:0] row_to_column_delay, dsz, sramW;
  logic burst_enable, mux_ext_bit, reqDram, reqArea2;
  logic [3:0] reqWb;
  logic [5:0] reqBytes, reqMask;
  assign memory_type_sel = bus_config_reg_one_q[sdbc_pkg::TYPE_LSB +: 3];
  assign mux_select = memory_ctrl_reg_q[sdbc_pkg::MUX_LSB +: 3];
  assign mux_ext_bit = memory_ctrl_reg_q[sdbc_pkg::MUXEXT_BIT];
  assign tpc = memory_ctrl_reg_q[sdbc_pkg::TPC_LSB +: 3];
  assign row_to_column_delay = memory_ctrl_reg_q[sdbc_pkg::RCD_LSB +: 2];
  assign burst_enable = memory_ctrl_reg_q[sdbc_pkg::BURST_BIT];
  assign dsz = memory_ctrl_reg_q[sdbc_pkg::DSZ_LSB +: 2];
  assign reqArea = reqAddr[28:26];
  assign sramW = bus_config_reg_one_q[sdbc_pkg::WIDTH_LSB + 2*reqArea +: 2];
  assign reqArea2 = reqArea == 3'h2 && memory_type_sel == sdbc_pkg::TYPE_A23;
  assign reqDram = reqArea2 || (reqArea == 3'h3 &&
                   (memory_type_sel == sdbc_pkg::TYPE_A3 || memory_type_sel == sdbc_pkg::TYPE_A23));
  always_comb begin
    if (reqDram) begin
      // 64 bits only when area 3 is the sole DRAM space
      if (dsz == sdbc_pkg::DSZ_64 && memory_type_sel == sdbc_pkg::TYPE_A3) begin
        reqWb = 4'h8;
      end else begin
        reqWb = (dsz == 2'h0) ? 4'h2 : 4'h4;
      end
    end else begin
      reqWb = 4'(4'h1 << sramW);
    end
    reqBytes = (reqSize == sdbc_pkg::SIZE_32B) ? 6'h20 : 6'(6'h1 << reqSize[1:0]);
    reqMask = (reqBytes > 6'(reqWb)) ? 6'(reqBytes - 6'h1) : 6'h0;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [4:0] cnt_q;
  logic [28:0] base_q;
  logic [5:0] off_q, mask_q;
  logic [3:0] wb_q;
  logic [2:0] area_q;
  logic [7:0] be_q;
  logic write_q, dram_q, area2_q, beatStart_q, wrTaken_q, done_q;
  logic [1:0] waitSync_q;
  logic [28:0] curAddr;
  logic [4:0] curWait;
  logic holdRead;
  assign curAddr = base_q | {23'h0, off_q};
  assign curWait = waitCycles(wait_count_reg_q[3*area_q +: 3]);
  assign holdRead = setup_hold_reg_q[area_q] && !write_q;
  assign reqReady = state_q == sdbc_pkg::ST_IDLE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitSync_q <= 2'b11;
    end else begin
      waitSync_q <= {waitSync_q[0], waitReqN};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= sdbc_pkg::ST_IDLE;
      cnt_q <= 5'h0;
      beatsLeft_q <= 6'h0;
      base_q <= 29'h0;
      off_q <= 6'h0;
      mask_q <= 6'h0;
      wb_q <= 4'h1;
      area_q <= 3'h0;
      be_q <= 8'h0;
      write_q <= 1'b0;
      dram_q <= 1'b0;
      area2_q <= 1'b0;
      beatStart_q <= 1'b0;
      wrTaken_q <= 1'b0;
      done_q <= 1'b0;
      dataOut <= 64'h0;
    end else begin
      beatStart_q <= 1'b0;
      wrTaken_q <= 1'b0;
      done_q <= 1'b0;
      unique case (state_q)
        sdbc_pkg::ST_IDLE: begin
          if (reqValid) begin
            base_q <= reqAddr & ~{23'h0, reqMask};
            off_q <= reqAddr[5:0] & reqMask & ~6'(reqWb - 4'h1);
            mask_q <= reqMask;
            wb_q <= reqWb;
            beatsLeft_q <= (reqMask == 6'h0) ? 6'h1 : 6'(reqBytes / 6'(reqWb));
            area_q <= reqArea;
            be_q <= reqBe;
            write_q <= reqWrite;
            dram_q <= reqDram;
            area2_q <= reqArea2;
            dataOut <= wrData;
            wrTaken_q <= reqWrite;
            beatStart_q <= 1'b1;
            cnt_q <= 5'({2'h0, tpc} + 5'h1);
            state_q <= reqDram ? sdbc_pkg::ST_PRE : sdbc_pkg::ST_FIRST;
          end
        end
        sdbc_pkg::ST_FIRST: begin
          cnt_q <= curWait;
          state_q <= (curWait != 5'h0) ? sdbc_pkg::ST_WAIT : sdbc_pkg::ST_SECOND;
        end
        sdbc_pkg::ST_WAIT: begin
          if (cnt_q > 5'h1) begin
            cnt_q <= cnt_q - 5'h1;
          end else if (waitSync_q[1]) begin
            state_q <= sdbc_pkg::ST_SECOND;
          end
          // External wait held low keeps the last wait state
        end
        sdbc_pkg::ST_SECOND: begin
          if (holdRead) begin
            state_q <= sdbc_pkg::ST_HOLD;
          end else if (beatsLeft_q > 6'h1) begin
            state_q <= sdbc_pkg::ST_FIRST;
            beatStart_q <= 1'b1;
            wrTaken_q <= write_q;
            dataOut <= wrData;
          end else begin
            state_q <= sdbc_pkg::ST_IDLE;
            done_q <= 1'b1;
          end
          beatsLeft_q <= beatsLeft_q - 6'h1;
          off_q <= (off_q + 6'(wb_q)) & mask_q;
        end
        sdbc_pkg::ST_HOLD: begin
          if (beatsLeft_q != 6'h0) begin
            state_q <= sdbc_pkg::ST_FIRST;
            beatStart_q <= 1'b1;
          end else begin
            state_q <= sdbc_pkg::ST_IDLE;
            done_q <= 1'b1;
          end
        end
        sdbc_pkg::ST_PRE: begin
          cnt_q <= cnt_q - 5'h1;
          if (cnt_q == 5'h1) begin
            cnt_q <= 5'({3'h0, row_to_column_delay} + 5'h1);
            state_q <= sdbc_pkg::ST_ROW;
          end
        end
        sdbc_pkg::ST_ROW: begin
          cnt_q <= cnt_q - 5'h1;
          if (cnt_q == 5'h1) begin
            cnt_q <= curWait + 5'h1;
            state_q <= sdbc_pkg::ST_COL;
          end
        end
        sdbc_pkg::ST_COL: begin
          cnt_q <= cnt_q - 5'h1;
          if (cnt_q == 5'h1) begin
            state_q <= sdbc_pkg::ST_LATCH;
          end
        end
        sdbc_pkg::ST_LATCH: begin
          beatsLeft_q <= beatsLeft_q - 6'h1;
          off_q <= (off_q + 6'(wb_q)) & mask_q;
          if (beatsLeft_q > 6'h1) begin
            beatStart_q <= 1'b1;
            wrTaken_q <= write_q;
            dataOut <= wrData;
            if (burst_enable) begin
              cnt_q <= curWait + 5'h1;
              state_q <= sdbc_pkg::ST_COL;
            end else begin
              cnt_q <= 5'({2'h0, tpc} + 5'h1);
              state_q <= sdbc_pkg::ST_PRE;
            end
          end else begin
            state_q <= sdbc_pkg::ST_IDLE;
            done_q <= 1'b1;
          end
        end
        default: state_q <= sdbc_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Read data capture through two flops
  // ----------------------------------------
  logic [63:0] din1_q, din2_q;
  logic [1:0] latPipe_q;
  logic latchNow;
  assign latchNow = !write_q && (state_q == sdbc_pkg::ST_LATCH || state_q == sdbc_pkg::ST_SECOND);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      din1_q <= 64'h0;
      din2_q <= 64'h0;
      latPipe_q <= 2'h0;
      rdData <= 64'h0;
      rdValid <= 1'b0;
    end else begin
      din1_q <= dataIn;
      din2_q <= din1_q;
      latPipe_q <= {latPipe_q[0], latchNow};
      rdValid <= latPipe_q[1];
      if (latPipe_q[1]) begin
        rdData <= din2_q;
      end
    end
  end

  // ----------------------------------------
  // Pin decode
  // ----------------------------------------
  logic sramActive, rasActive;
  logic [7:0] widthLanes, lanes, colLanes;
  assign sramActive = !dram_q && (state_q == sdbc_pkg::ST_FIRST || state_q == sdbc_pkg::ST_WAIT ||
                      state_q == sdbc_pkg::ST_SECOND);
  assign rasActive = dram_q && (state_q == sdbc_pkg::ST_ROW || state_q == sdbc_pkg::ST_COL ||
                     state_q == sdbc_pkg::ST_LATCH);
  assign widthLanes = 8'((9'h1 << wb_q) - 9'h1);
  assign lanes = (beatsLeft_q != 6'h0 && mask_q == 6'h0) ? (be_q & widthLanes) : widthLanes;
  assign wrTaken = wrTaken_q;
  assign done = done_q;
  assign busLock = state_q != sdbc_pkg::ST_IDLE;
  assign bus_start_pulseN = !beatStart_q;
  assign readStrobeN = !((sramActive || state_q == sdbc_pkg::ST_HOLD) && !write_q);
  assign writeStrobeN = (sramActive && write_q) ? ~lanes : 8'hff;
  assign rowStrobeN = !(rasActive && !area2_q);
  assign area2_row_strobeN = !(rasActive && area2_q);
  assign colLanes = write_q ? lanes : widthLanes;
  assign colStrobeN = (state_q == sdbc_pkg::ST_COL) ?
                      ~(area2_q ? 8'(colLanes << 4) : colLanes) : 8'hff;
  assign rdWr = !(write_q && busLock);
  assign dataOe = write_q && busLock;
  always_comb begin
    area_selectN = 7'h7f;
    if (sramActive) begin
      area_selectN[area_q] = 1'b0;
    end
    if (dram_q && (state_q == sdbc_pkg::ST_PRE || state_q == sdbc_pkg::ST_ROW)) begin
      addrOut = rowAddr(curAddr, mux_ext_bit ? 3'h0 : mux_select);
    end else begin
      addrOut = curAddr[25:0];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  bus_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    !bus_start_pulseN |=> bus_start_pulseN) else $error("bus start longer than one cycle");
  no_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_FIRST && curWait == 5'h0 |=> state_q == sdbc_pkg::ST_SECOND)
    else $error("no-wait access not two cycles");
  select_span_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_FIRST |-> !area_selectN[area_q]) else $error("area select missing");
  wait_insert_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_FIRST && curWait != 5'h0 |=> state_q == sdbc_pkg::ST_WAIT)
    else $error("wait state not inserted");
  ext_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_WAIT && cnt_q == 5'h1 && !waitSync_q[1] |=> state_q == sdbc_pkg::ST_WAIT)
    else $error("external wait ignored");
  read_lanes_a: assert property (@(posedge clk) disable iff (!arst_n)
    !write_q |-> writeStrobeN == 8'hff) else $error("write strobe on read");
  dram_basic_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_PRE && cnt_q == 5'h1 && row_to_column_delay == 2'h0 && curWait == 5'h0 |=>
    state_q == sdbc_pkg::ST_ROW ##1 state_q == sdbc_pkg::ST_COL ##1 state_q == sdbc_pkg::ST_LATCH)
    else $error("basic DRAM access not four states");
  fast_page_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_LATCH && burst_enable && beatsLeft_q > 6'h1 |=>
    state_q == sdbc_pkg::ST_COL && !(rowStrobeN && area2_row_strobeN)) else $error("fast page reopened row");
  sram_read_c: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_SECOND && !write_q);
  dram_burst_c: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_LATCH && burst_enable && beatsLeft_q > 6'h1);
  ext_wait_c: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == sdbc_pkg::ST_WAIT && cnt_q == 5'h1 && !waitSync_q[1]);
endmodule // sdbc_bus_cycles
`default_nettype wire

// file: src/sdbc_pkg.sv
// Package: register map, field layout and states of the SRAM/DRAM bus cycle block
package sdbc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_BUSCFG = 8'h00;
  localparam logic [7:0] OFS_WAIT = 8'h04;
  localparam logic [7:0] OFS_MEMCTL = 8'h08;
  localparam logic [7:0] OFS_HOLD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TYPE_LSB = 0;
  localparam int WIDTH_LSB = 8;
  localparam int MUX_LSB = 0;
  localparam int MUXEXT_BIT = 3;
  localparam int TPC_LSB = 4;
  localparam int RCD_LSB = 8;
  localparam int BURST_BIT = 10;
  localparam int DSZ_LSB = 12;
  localparam logic [2:0] TYPE_A3 = 3'h4;
  localparam logic [2:0] TYPE_A23 = 3'h5;
  localparam logic [1:0] DSZ_64 = 2'h2;
  localparam logic [2:0] SIZE_32B = 3'h4;
  localparam logic [4:0] MUX_BASE = 5'h08;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] BUSCFG_RST = 32'h002aaa00;
  localparam logic [31:0] WAIT_RST = 32'h00000000;
  localparam logic [31:0] MEMCTL_RST = 32'h00001000;
  localparam logic [31:0] HOLD_RST = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Wait states per 3-bit wait field
  localparam logic [31:0] WAIT_TABLE = 32'hfa643210;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_FIRST, ST_WAIT, ST_SECOND, ST_HOLD, ST_PRE, ST_ROW, ST_COL, ST_LATCH
  } sdbc_state_t;
endpackage

// file: verif/sdbc_mem_model.sv
// Memory chip model standing on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module sdbc_mem_model (
  input wire logic clk,
  input wire logic [25:0] addrOut,
  input wire logic readStrobeN,
  input wire logic [7:0] colStrobeN,
  input wire logic bus_start_pulseN,
  input wire logic [7:0] stallCycles,
  output logic [63:0] dataIn,
  output logic waitReqN
);
  logic [7:0] stallCnt;
  initial begin
    dataIn = 64'h0;
    waitReqN = 1'b1;
    stallCnt = 8'h00;
  end
  // ----------------------------------------
  // Data and wait
  // ----------------------------------------
  always @(posedge clk) begin
    if (!readStrobeN || colStrobeN != 8'hff) dataIn <= {2{6'h00, addrOut}};
    else dataIn <= ~dataIn;
    if (!bus_start_pulseN) stallCnt <= stallCycles;
    else if (stallCnt != 8'h00) stallCnt <= stallCnt - 8'h01;
    waitReqN <= !(stallCnt != 8'h00 || (!bus_start_pulseN && stallCycles != 8'h00));
  end
endmodule // sdbc_mem_model
`default_nettype wire

// file: verif/tb.sv
// Testbench for the SRAM and DRAM bus cycle block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reqValid, reqReady, reqWrite, wrTaken;
  logic rdValid, done, busLock, dataOe, waitReqN, bus_start_pulseN, readStrobeN, rowStrobeN, area2_row_strobeN, rdWr;
  logic [7:0] s_axi_awaddr, s_axi_araddr, reqBe, writeStrobeN, colStrobeN, stallCycles, casSeen, weSeen;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [28:0] reqAddr;
  logic [2:0] reqSize;
  logic [63:0] wrData, rdData, dataOut, dataIn;
  logic [25:0] addrOut, firstAddr, colAddr;
  logic [6:0] area_selectN;
  logic [25:0] beatAddr [$];
  logic [63:0] lastRd, wrOut;
  int err_total, samples_checked, lockCyc, bsCnt, csCyc, rasFalls, ras2Falls, rdCnt, wtCnt;
  int cm[3] = '{0, 1, 4};
  int cv[3] = '{0, 6, 2};
  int cr[3] = '{0, 3, 1};
  int cw[3] = '{0, 7, 3};
  int ce[3] = '{4, 28, 10};
  sdbc_bus_cycles dut_u (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reqValid, .reqReady, .reqWrite,
    .reqAddr, .reqSize, .reqBe, .wrData, .wrTaken, .rdData, .rdValid, .done, .busLock, .addrOut, .dataOut,
    .dataOe, .dataIn, .waitReqN, .bus_start_pulseN, .area_selectN, .readStrobeN, .writeStrobeN, .rowStrobeN,
    .area2_row_strobeN, .colStrobeN, .rdWr);
  sdbc_mem_model mem_u (.clk, .addrOut, .readStrobeN, .colStrobeN, .bus_start_pulseN, .stallCycles, .dataIn,
    .waitReqN);
  always #20 clk = ~clk;
  // ----------------------------------------
  // Bus monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if ($fell(rowStrobeN)) rasFalls++;
    if ($fell(area2_row_strobeN)) ras2Falls++;
    if (!area_selectN[1]) csCyc++;
    if (rdValid) begin
      lastRd = rdData;
      rdCnt++;
    end
    if (busLock) begin
      if (lockCyc == 0) firstAddr = addrOut;
      lockCyc++;
      if (!bus_start_pulseN) bsCnt++;
      if (!bus_start_pulseN) beatAddr.push_back(addrOut);
      if (casSeen == 8'h00 && colStrobeN != 8'hff) colAddr = addrOut;
      casSeen |= ~colStrobeN;
      weSeen |= ~writeStrobeN;
      if (dataOe) wrOut = dataOut;
      if (wrTaken) wtCnt++;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    n = 0;
    while (!s_axi_bvalid && n < 200) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    tmo(n);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    n = 0;
    while (!s_axi_rvalid && n < 200) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end
    rd = s_axi_rdata; rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic acc(input logic wr, input logic [28:0] a, input logic [2:0] sz, input logic [7:0] be);
    int n;
    lockCyc = 0; bsCnt = 0; csCyc = 0; rasFalls = 0; ras2Falls = 0; casSeen = 8'h00; weSeen = 8'h00;
    rdCnt = 0; wtCnt = 0; wrOut = 64'h0;
    beatAddr.delete();
    @(posedge clk);
    reqValid <= 1'b1; reqWrite <= wr; reqAddr <= a; reqSize <= sz; reqBe <= be;
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [16:0] rowOf(input logic [25:0] a, input int m);
    for (int k = 1; k <= 17; k++) rowOf[k-1] = (k + 8 + m <= 25) ? a[k+8+m] : a[k];
  endfunction
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0; arst_n = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf; reqValid = 1'b0; reqWrite = 1'b0; reqAddr = 29'h0;
    reqSize = 3'h0; reqBe = 8'h00; wrData = 64'h0123456789abcdef; stallCycles = 8'h00;
    err_total = 0; samples_checked = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    axr(sdbc_pkg::OFS_BUSCFG); `CHK(rd, sdbc_pkg::BUSCFG_RST)
    axr(sdbc_pkg::OFS_MEMCTL); `CHK(rd, sdbc_pkg::MEMCTL_RST)
    axr(8'h40); `CHK(rsp, sdbc_pkg::RESP_SLVERR)
    axw(8'h40, 32'h0); `CHK(rsp, sdbc_pkg::RESP_SLVERR)
    axw(sdbc_pkg::OFS_HOLD, 32'h0);
    acc(1'b0, {3'h1, 26'h0000124}, 3'h2, 8'h00);
    `CHK(lockCyc, 2)
    `CHK(bsCnt, 1)
    `CHK(csCyc, 2)
    `CHK(firstAddr, 26'h0000124)
    `CHK(rdCnt, 1)
    `CHK(lastRd[25:0], 26'h0000124)
    `CHK(reqReady, 1'b1)
    axw(sdbc_pkg::OFS_HOLD, 32'h2);
    acc(1'b0, {3'h1, 26'h0000124}, 3'h2, 8'h00);
    `CHK(lockCyc, 3)
    `CHK(csCyc, 2)
    axw(sdbc_pkg::OFS_HOLD, 32'h0);
    acc(1'b0, {3'h1, 26'h0000014}, sdbc_pkg::SIZE_32B, 8'h00);
    `CHK(lockCyc, 16)
    `CHK(bsCnt, 8)
    for (int i = 0; i < 8; i++) `CHK(beatAddr[i][4:0], 5'(20 + 4 * i))
    `CHK(rdCnt, 8)
    `CHK(lastRd[25:0], 26'h0000010)
    acc(1'b1, {3'h1, 26'h0000102}, 3'h0, 8'h04);
    `CHK(weSeen, 8'h04)
    `CHK(wrOut, wrData)
    `CHK(wtCnt, 1)
    `CHK(rdCnt, 0)
    stallCycles <= 8'h14;
    acc(1'b0, {3'h1, 26'h0000100}, 3'h2, 8'h00); `CHK(lockCyc, 2)
    axw(sdbc_pkg::OFS_WAIT, 32'h18);
    acc(1'b0, {3'h1, 26'h0000100}, 3'h2, 8'h00); `CHK(lockCyc > 5, 1'b1)
    stallCycles <= 8'h00;
    acc(1'b0, {3'h1, 26'h0000100}, 3'h2, 8'h00); `CHK(lockCyc, 5)
    axw(sdbc_pkg::OFS_BUSCFG, {sdbc_pkg::BUSCFG_RST[31:3], sdbc_pkg::TYPE_A3});
    for (int i = 0; i < 3; i++) begin
      axw(sdbc_pkg::OFS_MEMCTL, 32'(cm[i] + cv[i] * 16 + cr[i] * 256 + 4096));
      axw(sdbc_pkg::OFS_WAIT, 32'(cw[i] * 512));
      acc(1'b0, {3'h3, 26'h2a5b3c4}, 3'h2, 8'h00);
      `CHK(lockCyc, ce[i])
      `CHK(casSeen, 8'h0f)
      `CHK(firstAddr[17:1], rowOf(26'h2a5b3c4, cm[i]))
      `CHK(colAddr[17:1], 17'h0d9e2)
      `CHK(lastRd[25:0], 26'h2a5b3c4)
    end
    axw(sdbc_pkg::OFS_WAIT, 32'h0);
    for (int b = 0; b < 2; b++) begin
      axw(sdbc_pkg::OFS_MEMCTL, 32'h1000 | 32'(b * 1024));
      acc(1'b0, {3'h3, 26'h0000010}, sdbc_pkg::SIZE_32B, 8'h00);
      `CHK(rasFalls, b ? 1 : 8)
    end
    for (int z = 0; z < 3; z += 2) begin
      axw(sdbc_pkg::OFS_MEMCTL, 32'(z * 4096));
      acc(1'b0, {3'h3, 26'h0000040}, 3'h2, 8'h00);
      `CHK(casSeen, z ? 8'hff : 8'h03)
    end
    axw(sdbc_pkg::OFS_MEMCTL, 32'h1000);
    axw(sdbc_pkg::OFS_BUSCFG, {sdbc_pkg::BUSCFG_RST[31:3], sdbc_pkg::TYPE_A23});
    acc(1'b0, {3'h2, 26'h0000040}, 3'h2, 8'h00);
    `CHK(casSeen, 8'hf0)
    `CHK(ras2Falls + rasFalls * 2, 1)
    acc(1'b0, {3'h3, 26'h0000040}, 3'h2, 8'h00);
    `CHK(casSeen, 8'h0f)
    stop_test();
  end
endmodule // tb
`default_nettype wire
